// ===== shared/eas_consts.vh
// Constants for the edge angle stamp capture channel
`ifndef EAS_CONSTS_VH
`define EAS_CONSTS_VH

// Angle unit is 1/16 degree crank angle
`define EAS_ANG_W 14
`define EAS_ANG_FULL 14'd11520
`define EAS_RES_W 17

// Register byte offsets (word aligned)
`define EAS_OFS_CTRL 6'h00
`define EAS_OFS_WIN_START 6'h04
`define EAS_OFS_WIN_END 6'h08
`define EAS_OFS_REF 6'h0c
`define EAS_OFS_EDGE_NUM 6'h10
`define EAS_OFS_DEF_TMO 6'h14
`define EAS_OFS_CHK_PER 6'h18
`define EAS_OFS_RESULT 6'h1c
`define EAS_OFS_STATUS 6'h20
`define EAS_OFS_MASK 6'h24
`define EAS_OFS_EDGE_CNT 6'h28

// Control field positions
`define EAS_CTRL_RUN 0
`define EAS_CTRL_SYNC 1
`define EAS_CTRL_FALL 2
`define EAS_CTRL_NTH 3
`define EAS_CTRL_TMO_LO 4
`define EAS_CTRL_TMO_HI 6
`define EAS_CTRL_GATED 7
`define EAS_CTRL_ENA_LOW 8
`define EAS_CTRL_W 9

// Timeout options
`define EAS_TMO_NONE 3'h0
`define EAS_TMO_TIME_LVL 3'h1
`define EAS_TMO_CRANK_LVL 3'h2
`define EAS_TMO_DUAL_LVL 3'h3
`define EAS_TMO_TIME_DEF 3'h4
`define EAS_TMO_CRANK_DEF 3'h5
`define EAS_TMO_DUAL_DEF 3'h6

// Status bits
`define EAS_ST_NEW 0
`define EAS_ST_TMO 1
`define EAS_ST_W 2

// Reset values
`define EAS_RST_CTRL 9'h000
`define EAS_RST_ANG 14'h0000
`define EAS_RST_REF 16'h0000
`define EAS_RST_NUM 8'h00
`define EAS_RST_DEF 16'h0000
`define EAS_RST_PER 24'h000000
`define EAS_CHK_W 24

`endif

// ===== hdl/eas_sync2.v
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
module eas_sync2 (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire i_async,
	output wire o_sync
);
	reg meta_ff;
	reg sync_ff;

	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule // eas_sync2

// ===== hdl/eas_capture.v
// Edge angle stamp capture channel with Avalon-MM registers
//
// Summary of operation
// - Raw edge angle is always folded into zero up to below 720 degrees.
// - Sync mode maps raw angle into window start plus 720, then differences.
// - Result is reference angle minus mapped edge angle.
// - Reference accepts minus 720 to plus 720; async results within 1440.
// - Async mode differences the raw angle with no remapping.
// - Sync non-selective procedures capture every active edge inside window.
// - Sync selective captures n-th edge; counter clears passing window start.
// - Async non-selective procedures capture every active edge, no window.
// - Async mode clears the edge counter only on a control write; n-th edge caught once.
// - Edge number zero makes selective procedures capture every edge.
// - Timeout raised at check when no new result since previous check.
// - Level timeout options output channel level: 1 active, 0 inactive.
// - Active level is high for rising, low for falling procedures.
// - Predefined timeout options output the configured default value.
// - Enable-gated interval level timeout outputs Enable activity, 1 or 0.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "eas_consts.vh"
module eas_capture (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [5:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output wire [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	input wire [`EAS_ANG_W-1:0] i_crank_angle,
	input wire i_signal,
	input wire i_enable,
	output wire o_irq
);
	// Registers
	reg [`EAS_CTRL_W-1:0] ctrl_ff;
	reg [`EAS_ANG_W-1:0] win_start_ff;
	reg [`EAS_ANG_W-1:0] win_end_ff;
	reg [15:0] ref_ff;
	reg [7:0] edge_num_ff;
	reg [15:0] def_tmo_ff;
	reg [`EAS_CHK_W-1:0] chk_per_ff;
	reg [`EAS_RES_W-1:0] result_ff;
	reg [`EAS_ST_W-1:0] status_ff;
	reg [`EAS_ST_W-1:0] mask_ff;
	reg [7:0] edge_cnt_ff;
	reg [31:0] rdata_ff;
	reg wait_ff;
	reg irq_ff;
	// Capture state
	reg sig_prev_ff;
	reg [`EAS_ANG_W-1:0] off_prev_ff;
	reg [`EAS_CHK_W-1:0] chk_cnt_ff;
	reg fresh_ff;

	wire sig_s;
	wire ena_s;

	eas_sync2 u_sync_sig (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_async(i_signal),
		.o_sync(sig_s)
	);

	eas_sync2 u_sync_ena (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_async(i_enable),
		.o_sync(ena_s)
	);

	// Bus handshake: one wait state, then the access completes
	wire req = i_avs_read | i_avs_write;
	wire acc_wr = i_avs_write & ~wait_ff;
	wire acc_rd = i_avs_read & ~wait_ff;
	wire [31:0] wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
		{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	wire [31:0] wval_ctrl = ({23'h000000, ctrl_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_ws = ({18'h00000, win_start_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_we = ({18'h00000, win_end_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_ref = ({16'h0000, ref_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_num = ({24'h000000, edge_num_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_def = ({16'h0000, def_tmo_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_per = ({8'h00, chk_per_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	wire [31:0] wval_msk = ({30'h00000000, mask_ff} & ~wmask) |
		(i_avs_writedata & wmask);
	// A write to control reconfigures the channel and restarts counting
	wire cfg_wr = acc_wr && (i_avs_address == `EAS_OFS_CTRL);

	// Control fields
	wire run = ctrl_ff[`EAS_CTRL_RUN];
	wire sync_mode = ctrl_ff[`EAS_CTRL_SYNC];
	wire falling = ctrl_ff[`EAS_CTRL_FALL];
	wire nth = ctrl_ff[`EAS_CTRL_NTH];
	wire [2:0] tmo_opt = ctrl_ff[`EAS_CTRL_TMO_HI:`EAS_CTRL_TMO_LO];
	wire gated = ctrl_ff[`EAS_CTRL_GATED];
	wire ena_low = ctrl_ff[`EAS_CTRL_ENA_LOW];

	// Raw angle kept below one full cycle even if the base overshoots
	wire [`EAS_ANG_W-1:0] raw_ang = (i_crank_angle >= `EAS_ANG_FULL) ?
		(i_crank_angle - `EAS_ANG_FULL) : i_crank_angle;

	// Angle offsets relative to the window start, modulo one cycle
	wire [`EAS_ANG_W-1:0] off_cur = (raw_ang >= win_start_ff) ?
		(raw_ang - win_start_ff) :
		(raw_ang + `EAS_ANG_FULL - win_start_ff);
	wire [`EAS_ANG_W-1:0] off_end = (win_end_ff >= win_start_ff) ?
		(win_end_ff - win_start_ff) :
		(win_end_ff + `EAS_ANG_FULL - win_start_ff);
	// Equal limits give a window of a whole cycle
	wire in_win = (off_end == `EAS_RST_ANG) || (off_cur < off_end);
	// Offset falling back means the angle has just passed the window start
	wire start_pass = off_cur < off_prev_ff;

	// Mapped angle lies in [start, start + 720)
	wire [`EAS_ANG_W:0] mapped = {1'b0, win_start_ff} + {1'b0, off_cur};
	wire [`EAS_RES_W-1:0] ref_x = {ref_ff[15], ref_ff};
	wire [`EAS_RES_W-1:0] diff_sync = ref_x -
		{{(`EAS_RES_W-`EAS_ANG_W-1){1'b0}}, mapped};
	wire [`EAS_RES_W-1:0] diff_async = ref_x -
		{{(`EAS_RES_W-`EAS_ANG_W){1'b0}}, raw_ang};
	wire [`EAS_RES_W-1:0] ang_res = sync_mode ? diff_sync : diff_async;

	// Active edge detection on the synchronised channel
	wire rise = sig_s & ~sig_prev_ff;
	wire fall = ~sig_s & sig_prev_ff;
	wire act_edge = run & (falling ? fall : rise);
	wire edge_ok = act_edge & (~sync_mode | in_win);

	// Counter restarts at the window start in sync mode only
	wire cnt_clr = sync_mode & start_pass & run;
	wire [7:0] cnt_base = cnt_clr ? 8'h00 : edge_cnt_ff;
	// Saturating so that an async n-th edge can never be seen twice
	wire [7:0] cnt_inc = (cnt_base == 8'hff) ? cnt_base : cnt_base + 8'h01;
	wire sel_hit = (cnt_inc == edge_num_ff) && (cnt_base != 8'hff);
	wire capture = edge_ok & (~nth | (edge_num_ff == 8'h00) |
		sel_hit);

	// Timeout check strobe from a free-running period counter
	wire chk_now = run && (chk_per_ff != `EAS_RST_PER) &&
		(chk_cnt_ff == `EAS_RST_PER);
	wire tmo_hit = chk_now & ~fresh_ff & ~capture &
		(tmo_opt != `EAS_TMO_NONE) &
		(tmo_opt <= `EAS_TMO_DUAL_DEF);
	wire lvl_opt = (tmo_opt == `EAS_TMO_TIME_LVL) ||
		(tmo_opt == `EAS_TMO_CRANK_LVL) ||
		(tmo_opt == `EAS_TMO_DUAL_LVL);
	wire sig_act = falling ? ~sig_s : sig_s;
	wire ena_act = ena_low ? ~ena_s : ena_s;
	wire lvl_bit = gated ? ena_act : sig_act;
	wire [`EAS_RES_W-1:0] tmo_val = lvl_opt ?
		{{(`EAS_RES_W-1){1'b0}}, lvl_bit} :
		{def_tmo_ff[15], def_tmo_ff};

	wire [`EAS_ST_W-1:0] st_set = {tmo_hit, capture};

	// Configuration registers
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_ff <= `EAS_RST_CTRL;
			win_start_ff <= `EAS_RST_ANG;
			win_end_ff <= `EAS_RST_ANG;
			ref_ff <= `EAS_RST_REF;
			edge_num_ff <= `EAS_RST_NUM;
			def_tmo_ff <= `EAS_RST_DEF;
			chk_per_ff <= `EAS_RST_PER;
			mask_ff <= {`EAS_ST_W{1'b0}};
		end else if (acc_wr) begin
			if (i_avs_address == `EAS_OFS_CTRL) begin
				ctrl_ff <= wval_ctrl[`EAS_CTRL_W-1:0];
			end else if (i_avs_address == `EAS_OFS_WIN_START) begin
				win_start_ff <= wval_ws[`EAS_ANG_W-1:0];
			end else if (i_avs_address == `EAS_OFS_WIN_END) begin
				win_end_ff <= wval_we[`EAS_ANG_W-1:0];
			end else if (i_avs_address == `EAS_OFS_REF) begin
				ref_ff <= wval_ref[15:0];
			end else if (i_avs_address == `EAS_OFS_EDGE_NUM) begin
				edge_num_ff <= wval_num[7:0];
			end else if (i_avs_address == `EAS_OFS_DEF_TMO) begin
				def_tmo_ff <= wval_def[15:0];
			end else if (i_avs_address == `EAS_OFS_CHK_PER) begin
				chk_per_ff <= wval_per[`EAS_CHK_W-1:0];
			end else if (i_avs_address == `EAS_OFS_MASK) begin
				mask_ff <= wval_msk[`EAS_ST_W-1:0];
			end
		end
	end

	// Capture state, edge counter, check timer and result slot
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sig_prev_ff <= 1'b0;
			off_prev_ff <= `EAS_RST_ANG;
			edge_cnt_ff <= 8'h00;
			chk_cnt_ff <= `EAS_RST_PER;
			fresh_ff <= 1'b0;
			result_ff <= {`EAS_RES_W{1'b0}};
		end else begin
			sig_prev_ff <= sig_s;
			off_prev_ff <= off_cur;
			if (cfg_wr) begin
				edge_cnt_ff <= 8'h00;
				fresh_ff <= 1'b0;
				chk_cnt_ff <= chk_per_ff;
			end else begin
				if (edge_ok) begin
					edge_cnt_ff <= cnt_inc;
				end else begin
					edge_cnt_ff <= cnt_base;
				end
				// A result in the check cycle counts as new
				if (capture) begin
					fresh_ff <= 1'b1;
				end else if (chk_now) begin
					fresh_ff <= 1'b0;
				end
				if (chk_now) begin
					chk_cnt_ff <= chk_per_ff - 24'h000001;
				end else if (chk_cnt_ff != `EAS_RST_PER) begin
					chk_cnt_ff <= chk_cnt_ff - 24'h000001;
				end
			end
			if (capture) begin
				result_ff <= ang_res;
			end else if (tmo_hit) begin
				result_ff <= tmo_val;
			end
		end
	end

	// Bus answer, sticky status and interrupt
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
			status_ff <= {`EAS_ST_W{1'b0}};
			irq_ff <= 1'b0;
		end else begin
			wait_ff <= ~(req & wait_ff);
			// Read clears only the bits it reported, so later events survive
			if (acc_rd && (i_avs_address == `EAS_OFS_STATUS)) begin
				status_ff <= (status_ff & ~rdata_ff[`EAS_ST_W-1:0]) | st_set;
			end else begin
				status_ff <= status_ff | st_set;
			end
			irq_ff <= |(status_ff & mask_ff);
			if (i_avs_read & wait_ff) begin
				if (i_avs_address == `EAS_OFS_CTRL) begin
					rdata_ff <= {23'h000000, ctrl_ff};
				end else if (i_avs_address == `EAS_OFS_WIN_START) begin
					rdata_ff <= {18'h00000, win_start_ff};
				end else if (i_avs_address == `EAS_OFS_WIN_END) begin
					rdata_ff <= {18'h00000, win_end_ff};
				end else if (i_avs_address == `EAS_OFS_REF) begin
					rdata_ff <= {{16{ref_ff[15]}}, ref_ff};
				end else if (i_avs_address == `EAS_OFS_EDGE_NUM) begin
					rdata_ff <= {24'h000000, edge_num_ff};
				end else if (i_avs_address == `EAS_OFS_DEF_TMO) begin
					rdata_ff <= {{16{def_tmo_ff[15]}}, def_tmo_ff};
				end else if (i_avs_address == `EAS_OFS_CHK_PER) begin
					rdata_ff <= {8'h00, chk_per_ff};
				end else if (i_avs_address == `EAS_OFS_RESULT) begin
					rdata_ff <= {{(32-`EAS_RES_W){result_ff[`EAS_RES_W-1]}},
						result_ff};
				end else if (i_avs_address == `EAS_OFS_STATUS) begin
					rdata_ff <= {30'h00000000, status_ff};
				end else if (i_avs_address == `EAS_OFS_MASK) begin
					rdata_ff <= {30'h00000000, mask_ff};
				end else if (i_avs_address == `EAS_OFS_EDGE_CNT) begin
					rdata_ff <= {24'h000000, edge_cnt_ff};
				end else begin
					rdata_ff <= 32'h00000000;
				end
			end
		end
	end

	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_irq = irq_ff;
endmodule // eas_capture

// ===== dv/eas_capture_checker.sv
// Bus, result and interrupt assertions for the capture channel
`timescale 1ns/10ps
`include "eas_consts.vh"
module eas_capture_checker (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire [5:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	input wire [`EAS_ANG_W-1:0] i_crank_angle,
	input wire i_signal,
	input wire i_enable,
	input wire o_irq
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);
	wire done = !o_avs_waitrequest;
	wire rd_done = i_avs_read && done;
	wire wr_lo = i_avs_write && done && i_avs_byteenable[0];
	wire res_rd = rd_done && i_avs_address == `EAS_OFS_RESULT;
	wire signed [31:0] res = o_avs_readdata;
	// Mode is tracked here so the span check knows which range applies
	reg sync_ff;
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn)
			sync_ff <= 1'b0;
		else if (wr_lo && i_avs_address == `EAS_OFS_CTRL)
			sync_ff <= i_avs_writedata[`EAS_CTRL_SYNC];
	end
	chk_wait_one: assert property ((i_avs_read || i_avs_write) &&
		o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
	chk_wait_pulse: assert property (!o_avs_waitrequest |=>
		o_avs_waitrequest) else $error("wait low too long");
	chk_wait_idle: assert property (!(i_avs_read || i_avs_write) |=>
		o_avs_waitrequest) else $error("answer without request");
	chk_unmapped_zero: assert property (rd_done && i_avs_address >
		`EAS_OFS_EDGE_CNT |-> o_avs_readdata == 32'h0) else $error("unmapped");
	chk_async_span: assert property (
		res_rd && !sync_ff |-> res > -23040 && res <= 11520)
		else $error("async result out of span");
	chk_status_width: assert property (rd_done && i_avs_address ==
		`EAS_OFS_STATUS |-> o_avs_readdata[31:`EAS_ST_W] == 0)
		else $error("status spare bits");
	chk_count_width: assert property (rd_done && i_avs_address ==
		`EAS_OFS_EDGE_CNT |-> o_avs_readdata[31:8] == 0)
		else $error("edge count spare bits");
	chk_read_stable: assert property (
		!$stable(o_avs_readdata) |-> $past(i_avs_read))
		else $error("read data moved without read");
	chk_irq_masked: assert property (wr_lo && i_avs_address ==
		`EAS_OFS_MASK && i_avs_writedata[1:0] == 2'h0 |-> ##2 !o_irq)
		else $error("irq while masked");
endmodule // eas_capture_checker
bind eas_capture eas_capture_checker chk_u (.i_clk_sys(i_clk_sys),
	.i_resetn(i_resetn), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.i_crank_angle(i_crank_angle), .i_signal(i_signal),
	.i_enable(i_enable), .o_irq(o_irq));

// ===== dv/eas_bench_model.sv
// Engine bench model: crank angle source and channel and Enable pins
`timescale 1ns/10ps
`include "eas_consts.vh"
module eas_bench_model (
	input wire i_clk_sys,
	input wire i_resetn,
	input wire i_load,
	input wire [`EAS_ANG_W-1:0] i_load_angle,
	input wire i_level,
	input wire i_ena_level,
	output reg [`EAS_ANG_W-1:0] o_crank_angle,
	output reg o_signal,
	output reg o_enable
);
	// Angle is held between loads so each edge has a known stamp
	always @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_crank_angle <= 14'h0000;
			o_signal <= 1'b0;
			o_enable <= 1'b0;
		end else begin
			if (i_load)
				o_crank_angle <= i_load_angle;
			o_signal <= i_level;
			o_enable <= i_ena_level;
		end
	end
endmodule // eas_bench_model

// ===== dv/test_edge_angle_stamp_capture.sv
// Self-checking bench for the edge angle stamp capture channel
`timescale 1ns/10ps
`include "eas_consts.vh"
module test_edge_angle_stamp_capture;
	reg i_clk_sys = 1'b0;
	reg i_resetn = 1'b0;
	reg [5:0] adr = 6'h00;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [31:0] wd = 32'h00000000;
	wire [31:0] rdat;
	wire wrq;
	wire irq;
	wire [`EAS_ANG_W-1:0] ang;
	wire sig;
	wire ena;
	reg ld = 1'b0;
	reg [`EAS_ANG_W-1:0] ld_ang = 14'h0000;
	reg lvl = 1'b0;
	reg ena_lvl = 1'b1;
	int fails = 0;
	int compares = 0;
	logic [31:0] rv;
	int i, j, n, r, s;
	int a [3];
	logic [31:0] tc [9] = '{32'h11, 32'h21, 32'h31, 32'h41, 32'h51,
		32'h61, 32'h25, 32'h91, 32'h191};
	logic [31:0] te [9] = '{32'h1, 32'h1, 32'h1, 32'hfffff123,
		32'hfffff123, 32'hfffff123, 32'h0, 32'h1, 32'h0};
	eas_bench_model model_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_load(ld), .i_load_angle(ld_ang), .i_level(lvl),
		.i_ena_level(ena_lvl), .o_crank_angle(ang), .o_signal(sig),
		.o_enable(ena));
	eas_capture dut_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
		.i_crank_angle(ang), .i_signal(sig), .i_enable(ena), .o_irq(irq));
	initial begin
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	task automatic complete_run;
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge i_clk_sys);
	endtask
	task automatic bus(input bit w, input logic [5:0] ad, input int d);
		int k;
		k = 0;
		adr <= ad;
		wd <= d;
		wr <= w;
		rd <= !w;
		tick(1);
		while (wrq !== 1'b0) begin
			k++;
			if (k > 20) begin
				fails++;
				complete_run();
			end
			tick(1);
		end
		rv = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		tick(1);
	endtask
	// Inactive level first lets the synchroniser settle before the edge
	task automatic edge_at(input int an, input bit v);
		ld <= 1'b1;
		ld_ang <= 14'(an);
		lvl <= !v;
		tick(6);
		ld <= 1'b0;
		lvl <= v;
		tick(8);
	endtask
	function automatic int expv(input int rf, an, st, input bit sy);
		return sy ? rf - (st + (an - st + 11520) % 11520) : rf - an;
	endfunction
	initial begin
		i = $urandom(46554);
		tick(8);
		i_resetn <= 1'b1;
		tick(1);
		for (i = 0; i < 12; i++) begin
			bus(0, 6'(i * 4), 0);
			chk(rv, 0);
		end
		bus(1, 6'h3c, -1);
		bus(0, 6'h3c, 0);
		chk(rv, 0);
		$display("reset test done");
		for (i = 0; i < 12; i++) begin
			n = i / 6;
			r = i % 6 == 0 ? -11520 : i % 6 == 1 ? 11520 : $urandom % 23041 - 11520;
			a[0] = i % 6 == 0 ? 11519 : $urandom % 11520;
			s = $urandom % 11520;
			bus(1, `EAS_OFS_REF, r);
			bus(1, `EAS_OFS_WIN_START, s);
			bus(1, `EAS_OFS_WIN_END, s);
			bus(1, `EAS_OFS_CTRL, 1 | n << 1 | (i & 1) << 2);
			edge_at(a[0], !(i & 1));
			bus(0, `EAS_OFS_RESULT, 0);
			chk(rv, expv(r, a[0], s, n[0]));
			bus(0, `EAS_OFS_STATUS, 0);
			chk(rv, 1);
		end
		$display("stamp test done");
		bus(1, `EAS_OFS_WIN_START, 0);
		bus(1, `EAS_OFS_WIN_END, 0);
		for (n = 2; n >= 0; n -= 2) begin
			bus(1, `EAS_OFS_EDGE_NUM, n);
			bus(1, `EAS_OFS_CTRL, 32'h9);
			for (j = 0; j < 3; j++) begin
				a[j] = (2 - j) * 3000 + $urandom % 1000;
				edge_at(a[j], 1);
				bus(0, `EAS_OFS_STATUS, 0);
				chk(rv, n == 0 || j == 1);
			end
			bus(0, `EAS_OFS_RESULT, 0);
			chk(rv, expv(r, a[n ? 1 : 2], 0, 0));
			bus(0, `EAS_OFS_EDGE_CNT, 0);
			chk(rv, 3);
		end
		bus(1, `EAS_OFS_WIN_END, 1600);
		bus(1, `EAS_OFS_CTRL, 32'h3);
		edge_at(4000, 1);
		bus(0, `EAS_OFS_STATUS, 0);
		chk(rv, 0);
		bus(1, `EAS_OFS_WIN_START, 2000);
		bus(1, `EAS_OFS_WIN_END, 2000);
		bus(1, `EAS_OFS_EDGE_NUM, 1);
		bus(1, `EAS_OFS_CTRL, 32'hb);
		edge_at(2100, 1);
		edge_at(2200, 1);
		bus(0, `EAS_OFS_RESULT, 0);
		chk(rv, r - 2100);
		edge_at(2050, 1);
		bus(0, `EAS_OFS_RESULT, 0);
		chk(rv, r - 2050);
		$display("edge select test done");
		bus(1, `EAS_OFS_DEF_TMO, 32'hf123);
		bus(1, `EAS_OFS_CHK_PER, 20);
		for (i = 0; i < 9; i++) begin
			bus(1, `EAS_OFS_CTRL, tc[i]);
			tick(30);
			bus(0, `EAS_OFS_RESULT, 0);
			chk(rv, te[i]);
			bus(0, `EAS_OFS_STATUS, 0);
			chk(rv & 2, 2);
		end
		bus(1, `EAS_OFS_CHK_PER, 40);
		bus(1, `EAS_OFS_CTRL, 32'h41);
		// The old period still fires one check before the restart
		bus(0, `EAS_OFS_STATUS, 0);
		for (j = 0; j < 4; j++) begin
			edge_at(100 * j, 1);
			bus(0, `EAS_OFS_STATUS, 0);
			chk(rv, 1);
		end
		$display("timeout test done");
		bus(1, `EAS_OFS_MASK, 2);
		tick(60);
		chk(irq, 1);
		bus(1, `EAS_OFS_MASK, 0);
		tick(2);
		chk(irq, 0);
		bus(1, `EAS_OFS_CHK_PER, 0);
		bus(1, `EAS_OFS_CTRL, 32'h41);
		bus(1, `EAS_OFS_MASK, 2);
		bus(0, `EAS_OFS_STATUS, 0);
		tick(3);
		chk(irq, 0);
		$display("interrupt test done");
		complete_run();
	end
endmodule // test_edge_angle_stamp_capture
